// File: rtl/ctu_top.v
// Charge time unit edge control with APB register access
//
// Summary of operation
// R1 - Sleep always turns the current source off
// R2 - Idle with stop bit clear keeps running
// R3 - Idle with stop bit set stops source
// R4 - Reset clears all unit registers
// R5 - Software discharges residual charge after reset
// R6 - Enable bit turns the unit on
// R7 - Edge enable bit blocks or passes edges
// R8 - Sequence bit requires edge 1 first
// R9 - Discharge bit grounds the source output
// R10 - Trigger bit gates the converter trigger
// R11 - Edge 2 polarity selects rising or falling
// R12 - Edge 2 source field picks source
// R13 - Edge 1 polarity selects rising or falling
// R14 - Edge 1 source field, same encoding
// R15 - Edge 2 status set by qualifying edge
// R16 - Edge 1 status set by qualifying edge
// R17 - Trim field is signed adjustment
// R18 - Range field selects current or off
// R19 - Time generation pulses until comparator trips
// R20 - Software may charge by writing status
// R21 - Source on while edge1 set, edge2 clear
// R22 - High register bit 6 reads zero
`timescale 1ns/10ps
`default_nettype none
`include "ctu_consts.vh"

module ctu_top
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        edge_pin_one,
  input  wire        edge_pin_two,
  input  wire        compare_one_event,
  input  wire        compare_two_event,
  input  wire        comparator_trip,
  output reg         current_source_on,
  output reg  [1:0]  current_range,
  output reg  [5:0]  current_trim,
  output reg         source_grounded,
  output reg         converter_trigger,
  output wire        pulse_output_pin
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg  [7:0] unit_control_high;
  reg  [7:0] unit_control_low;
  reg  [7:0] current_source_control;
  reg  [1:0] power_mode;
  wire       wr_en;
  wire       rd_en;
  wire       addr_ok;
  wire       e1_pulse;
  wire       e2_pulse;
  wire       e1_take;
  wire       e2_take;
  wire       source_halted;
  wire       module_enable;
  wire       edge_enable;
  wire       edge_sequence_enable;
  wire [3:0] sources;
  reg  [7:0] next_low;

  assign module_enable        = unit_control_high[`CTU_H_ENABLE];
  assign edge_enable          = unit_control_high[`CTU_H_EDGE_EN];
  assign edge_sequence_enable = unit_control_high[`CTU_H_EDGE_SEQ];
  assign sources = {compare_two_event, compare_one_event, edge_pin_two, edge_pin_one};

  // ****************************************************************
  // APB decode, zero wait states
  // ****************************************************************
  assign addr_ok = (paddr == `CTU_ADDR_CON_HIGH) || (paddr == `CTU_ADDR_CON_LOW) ||
                   (paddr == `CTU_ADDR_CUR_CTRL) || (paddr == `CTU_ADDR_POWER) ||
                   (paddr == `CTU_ADDR_STATE);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign wr_en   = psel & penable & pwrite & addr_ok;
  assign rd_en   = psel & ~penable & ~pwrite;

  // ****************************************************************
  // Edge detectors per channel
  // ****************************************************************
  ctu_edge_detect u_edge1
  (
    .pclk          (pclk),
    .presetn       (presetn),
    .source_select (unit_control_low[`CTU_L_E1_SEL_HI:`CTU_L_E1_SEL_LO]), // R14
    .polarity      (unit_control_low[`CTU_L_E1_POL]), // R13
    .source_in     (sources),
    .edge_pulse    (e1_pulse)
  );

  ctu_edge_detect u_edge2
  (
    .pclk          (pclk),
    .presetn       (presetn),
    .source_select (unit_control_low[`CTU_L_E2_SEL_HI:`CTU_L_E2_SEL_LO]), // R12
    .polarity      (unit_control_low[`CTU_L_E2_POL]), // R11
    .source_in     (sources),
    .edge_pulse    (e2_pulse)
  );

  // Qualified edge events
  assign e1_take = module_enable & edge_enable & e1_pulse; // R7
  assign e2_take = module_enable & edge_enable & e2_pulse &
                   (~edge_sequence_enable | unit_control_low[`CTU_L_E1_STAT]); // R8

  // ****************************************************************
  // Control low next value: edge set wins over software write
  // ****************************************************************
  always @*
  begin
    next_low = unit_control_low;
    if (wr_en && paddr == `CTU_ADDR_CON_LOW)
      next_low = pwdata[7:0]; // R20
    if (e1_take)
      next_low[`CTU_L_E1_STAT] = 1'b1; // R16
    if (e2_take)
      next_low[`CTU_L_E2_STAT] = 1'b1; // R15
  end

  // ****************************************************************
  // Register writes
  // ****************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      unit_control_high      <= `CTU_REG_RESET; // R4
      unit_control_low       <= `CTU_REG_RESET;
      current_source_control <= `CTU_REG_RESET;
      power_mode             <= 2'b00;
    end
    else
    begin
      unit_control_low <= next_low;
      if (wr_en && paddr == `CTU_ADDR_CON_HIGH)
        unit_control_high <= pwdata[7:0] & `CTU_H_WMASK; // R22
      if (wr_en && paddr == `CTU_ADDR_CUR_CTRL)
        current_source_control <= pwdata[7:0];
      if (wr_en && paddr == `CTU_ADDR_POWER)
        power_mode <= pwdata[1:0];
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (rd_en)
    begin
      case (paddr)
        `CTU_ADDR_CON_HIGH: prdata <= {24'h00_0000, unit_control_high};
        `CTU_ADDR_CON_LOW:  prdata <= {24'h00_0000, unit_control_low};
        `CTU_ADDR_CUR_CTRL: prdata <= {24'h00_0000, current_source_control};
        `CTU_ADDR_POWER:    prdata <= {30'h0000_0000, power_mode};
        `CTU_ADDR_STATE:    prdata <= {30'h0000_0000, source_halted, current_source_on};
        default:            prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // Low power stop of the current source
  // ****************************************************************
  assign source_halted = power_mode[`CTU_PWR_SLEEP] | // R1
                         (power_mode[`CTU_PWR_IDLE] &
                          unit_control_high[`CTU_H_STOP_IDLE]); // R2 R3

  // ****************************************************************
  // Analog and trigger controls
  // ****************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      current_source_on <= 1'b0;
      current_range     <= `CTU_RNG_OFF;
      current_trim      <= 6'h00;
      source_grounded   <= 1'b0;
      converter_trigger <= 1'b0;
    end
    else
    begin
      current_source_on <= module_enable & ~source_halted & // R6 R1 R3
                           (current_source_control[1:0] != `CTU_RNG_OFF) & // R18
                           unit_control_low[`CTU_L_E1_STAT] &
                           ~unit_control_low[`CTU_L_E2_STAT]; // R21
      current_range     <= current_source_control[1:0]; // R18
      current_trim      <= current_source_control[7:2]; // R17
      source_grounded   <= unit_control_high[`CTU_H_DISCHARGE]; // R9
      converter_trigger <= module_enable & unit_control_high[`CTU_H_TRIGGER] &
                           unit_control_low[`CTU_L_E2_STAT]; // R10
    end
  end

  // ****************************************************************
  // Delay generation pulse
  // ****************************************************************
  ctu_pulse_gen u_pulse
  (
    .pclk            (pclk),
    .presetn         (presetn),
    .enable          (module_enable & unit_control_high[`CTU_H_TIME_GEN]), // R19
    .charging        (current_source_on),
    .comparator_trip (comparator_trip),
    .pulse_out       (pulse_output_pin)
  );

endmodule
`default_nettype wire

// File: rtl/ctu_consts.vh
// Constants for the charge time unit edge control block
`ifndef CTU_CONSTS_VH
`define CTU_CONSTS_VH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define CTU_ADDR_CON_HIGH       12'h000
`define CTU_ADDR_CON_LOW        12'h004
`define CTU_ADDR_CUR_CTRL       12'h008
`define CTU_ADDR_POWER          12'h00C
`define CTU_ADDR_STATE          12'h010

// ****************************************************************
// Control high fields
// ****************************************************************
`define CTU_H_ENABLE            7
`define CTU_H_RESERVED          6
`define CTU_H_STOP_IDLE         5
`define CTU_H_TIME_GEN          4
`define CTU_H_EDGE_EN           3
`define CTU_H_EDGE_SEQ          2
`define CTU_H_DISCHARGE         1
`define CTU_H_TRIGGER           0
`define CTU_H_WMASK             8'hBF

// ****************************************************************
// Control low fields
// ****************************************************************
`define CTU_L_E2_POL            7
`define CTU_L_E2_SEL_HI         6
`define CTU_L_E2_SEL_LO         5
`define CTU_L_E1_POL            4
`define CTU_L_E1_SEL_HI         3
`define CTU_L_E1_SEL_LO         2
`define CTU_L_E2_STAT           1
`define CTU_L_E1_STAT           0

// ****************************************************************
// Source select codes
// ****************************************************************
`define CTU_SEL_PIN_ONE         2'b11
`define CTU_SEL_PIN_TWO         2'b10
`define CTU_SEL_COMPARE_ONE     2'b01
`define CTU_SEL_COMPARE_TWO     2'b00

// ****************************************************************
// Current range codes and reset value
// ****************************************************************
`define CTU_RNG_OFF             2'b00
`define CTU_RNG_BASE            2'b01
`define CTU_RNG_TEN             2'b10
`define CTU_RNG_HUNDRED         2'b11
`define CTU_REG_RESET           8'h00

// ****************************************************************
// Power mode field (power register bits 1-0)
// ****************************************************************
`define CTU_PWR_IDLE            0
`define CTU_PWR_SLEEP           1

`endif

// File: rtl/ctu_edge_detect.v
// Edge source select and polarity detector for one edge channel
`timescale 1ns/10ps
`default_nettype none
`include "ctu_consts.vh"

module ctu_edge_detect
(
  input  wire       pclk,
  input  wire       presetn,
  input  wire [1:0] source_select,
  input  wire       polarity,
  input  wire [3:0] source_in,
  output reg        edge_pulse
);

  // ****************************************************************
  // Source mux and edge detection
  // ****************************************************************
  reg  sel_level;
  reg  last_level;

  always @*
  begin
    case (source_select)
      `CTU_SEL_PIN_ONE:     sel_level = source_in[0];
      `CTU_SEL_PIN_TWO:     sel_level = source_in[1];
      `CTU_SEL_COMPARE_ONE: sel_level = source_in[2];
      default:              sel_level = source_in[3];
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      last_level <= 1'b0;
      edge_pulse <= 1'b0;
    end
    else
    begin
      last_level <= sel_level;
      if (polarity)
        edge_pulse <= sel_level & ~last_level;
      else
        edge_pulse <= ~sel_level & last_level;
    end
  end

endmodule
`default_nettype wire

// File: rtl/ctu_pulse_gen.v
// Delay generation pulse output driven by the comparator trip
`timescale 1ns/10ps
`default_nettype none

module ctu_pulse_gen
(
  input  wire pclk,
  input  wire presetn,
  input  wire enable,
  input  wire charging,
  input  wire comparator_trip,
  output reg  pulse_out
);

  // ****************************************************************
  // Pulse high from charge start until trip
  // ****************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pulse_out <= 1'b0;
    else if (!enable || !charging)
      pulse_out <= 1'b0;
    else
      pulse_out <= ~comparator_trip;
  end

endmodule
`default_nettype wire

// File: tb/ctu_far_side.sv
// Edge sources and charged capacitor facing the charge time unit
`timescale 1ns/10ps
`default_nettype none
module ctu_far_side
#(
  parameter int HOLD = 12,
  parameter int TRIP = 10
)
(
  input  wire logic       pclk,
  input  wire logic       go,
  input  wire logic [1:0] code,
  input  wire logic       charging,
  input  wire logic       grounded,
  output logic      [3:0] src,
  output logic            trip
);
  int         hold_cnt = 0;
  int         charge   = 0;
  logic [1:0] sel      = 2'b00;
  always @(posedge pclk)
  begin
    if (go)
      sel <= code;
    hold_cnt <= go ? HOLD : (hold_cnt > 0 ? hold_cnt - 1 : 0);
    if (grounded)
      charge <= 0;
    else if (charging && charge < TRIP)
      charge <= charge + 1;
  end
  assign src  = (hold_cnt > 0) ? 4'h1 << sel : 4'h0;
  assign trip = (charge >= TRIP);
endmodule
`default_nettype wire

// File: tb/ctu_chk.sv
// Port assertions for the charge time unit top
`timescale 1ns/10ps
`default_nettype none
`include "ctu_consts.vh"
module ctu_chk
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        comparator_trip,
  input wire logic        current_source_on,
  input wire logic [1:0]  current_range,
  input wire logic [5:0]  current_trim,
  input wire logic        source_grounded,
  input wire logic        converter_trigger,
  input wire logic        pulse_output_pin
);
  wire logic wr = psel && penable && pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rst;
    $rose(presetn) |-> !current_source_on && !converter_trigger && current_trim == 6'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not clear after reset");
  property p_rsv;
    psel && penable && !pwrite && paddr == `CTU_ADDR_CON_HIGH |-> !prdata[6];
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit reads one");
  property p_gnd;
    wr && paddr == `CTU_ADDR_CON_HIGH |-> ##2 source_grounded == $past(pwdata[1], 2);
  endproperty
  a_gnd: assert property (p_gnd) else $error("ground output wrong");
  property p_cur;
    wr && paddr == `CTU_ADDR_CUR_CTRL |-> ##2
      current_range == $past(pwdata[1:0], 2) && current_trim == $past(pwdata[7:2], 2);
  endproperty
  a_cur: assert property (p_cur) else $error("range or trim output wrong");
  property p_slp;
    wr && paddr == `CTU_ADDR_POWER && pwdata[1] |-> ##2 !current_source_on;
  endproperty
  a_slp: assert property (p_slp) else $error("source on in sleep");
  property p_off;
    current_source_on |-> current_range != 2'b00;
  endproperty
  a_off: assert property (p_off) else $error("source on with range off");
  property p_excl;
    !(current_source_on && converter_trigger);
  endproperty
  a_excl: assert property (p_excl) else $error("source on after edge 2");
  property p_pls;
    pulse_output_pin |-> !$past(comparator_trip);
  endproperty
  a_pls: assert property (p_pls) else $error("pulse after trip");
  property p_err;
    psel && penable && paddr > `CTU_ADDR_STATE |-> pslverr && (pwrite || prdata == 32'h0000_0000);
  endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
endmodule
bind ctu_top ctu_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pslverr, .comparator_trip, .current_source_on, .current_range, .current_trim,
  .source_grounded, .converter_trigger, .pulse_output_pin);
`default_nettype wire

// File: tb/tb_charge_time_edge_control.sv
// Self-checking bench for the charge time unit edge control
`timescale 1ns/10ps
`default_nettype none
`include "ctu_consts.vh"
module tb_charge_time_edge_control;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        go = 1'b0;
  logic [1:0]  code = 2'b00;
  logic [31:0] rdv;
  logic        errv;
  int          num_errors = 0;
  int          compares = 0;
  int          cycles = 0;
  wire logic [31:0] prdata;
  wire logic [3:0]  src;
  wire logic [1:0]  current_range;
  wire logic [5:0]  current_trim;
  wire logic        pready, pslverr, comparator_trip, current_source_on;
  wire logic        source_grounded, converter_trigger, pulse_output_pin;
  wire logic [31:0] outs = {20'h0_0000, pulse_output_pin, converter_trigger,
    source_grounded, current_source_on, current_trim, current_range};
  ctu_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .edge_pin_one(src[3]), .edge_pin_two(src[2]),
    .compare_one_event(src[1]), .compare_two_event(src[0]), .comparator_trip,
    .current_source_on, .current_range, .current_trim, .source_grounded,
    .converter_trigger, .pulse_output_pin);
  ctu_far_side u_far (.pclk, .go, .code, .charging(current_source_on),
    .grounded(source_grounded), .src, .trip(comparator_trip));
  initial
    forever #12.5 pclk = ~pclk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
  endtask
  task automatic fire(input logic [1:0] c, input int k);
    @(posedge pclk);
    go <= 1'b1;
    code <= c;
    @(posedge pclk);
    go <= 1'b0;
    tick(k);
  endtask
  task automatic t_reset;
    chk(outs, 32'h0000_0000);
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, 12'(4 * i), 32'h0000_0000);
      chk(rdv, 32'h0000_0000);
    end
    $display("reset test done");
  endtask
  task automatic t_regs;
    apb(1'b1, `CTU_ADDR_CON_HIGH, 32'h0000_00FF);
    apb(1'b0, `CTU_ADDR_CON_HIGH, 32'h0000_0000);
    chk(rdv, 32'h0000_00BF);
    chk(outs, 32'h0000_0200);
    apb(1'b1, `CTU_ADDR_CON_HIGH, 32'h0000_0000);
    apb(1'b1, `CTU_ADDR_CUR_CTRL, 32'h0000_0086);
    apb(1'b0, `CTU_ADDR_CUR_CTRL, 32'h0000_0000);
    chk(rdv, 32'h0000_0086);
    chk(outs, 32'h0000_0086);
    apb(1'b0, 12'h100, 32'h0000_0000);
    chk({rdv[30:0], errv}, 32'h0000_0001);
    $display("register test done");
  endtask
  task automatic t_edge;
    apb(1'b1, `CTU_ADDR_CUR_CTRL, 32'h0000_0001);
    apb(1'b1, `CTU_ADDR_CON_HIGH, 32'h0000_0089);
    for (int c = 0; c < 4; c++)
    begin
      apb(1'b1, `CTU_ADDR_CON_LOW, 32'(16 + 36 * c));
      fire(2'(c), 5);
      chk(outs, 32'h0000_0101);
      apb(1'b0, `CTU_ADDR_CON_LOW, 32'h0000_0000);
      chk(rdv, 32'(17 + 36 * c));
      tick(10);
      chk(outs, 32'h0000_0401);
      apb(1'b0, `CTU_ADDR_CON_LOW, 32'h0000_0000);
      chk(rdv, 32'(19 + 36 * c));
    end
    $display("edge test done");
  endtask
  task automatic t_block;
    logic [31:0] hi [4] = '{32'h81, 32'h0D, 32'h8C, 32'h88};
    logic [31:0] lo [4] = '{32'hDC, 32'hDC, 32'hDC, 32'hDE};
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, `CTU_ADDR_CON_LOW, 32'h0000_00DC);
      apb(1'b1, `CTU_ADDR_CON_HIGH, hi[i]);
      fire(i == 1 ? 2'b11 : 2'b10, 16);
      apb(1'b0, `CTU_ADDR_CON_LOW, 32'h0000_0000);
      chk(rdv, lo[i]);
    end
    $display("blocking test done");
  endtask
  task automatic t_power;
    apb(1'b1, `CTU_ADDR_CON_HIGH, 32'h0000_0092);
    apb(1'b1, `CTU_ADDR_CON_HIGH, 32'h0000_0090);
    apb(1'b1, `CTU_ADDR_CON_LOW, 32'h0000_0001);
    tick(3);
    chk(outs, 32'h0000_0901);
    tick(12);
    chk(outs, 32'h0000_0101);
    apb(1'b1, `CTU_ADDR_POWER, 32'h0000_0001);
    tick(3);
    chk(outs, 32'h0000_0101);
    apb(1'b1, `CTU_ADDR_CON_HIGH, 32'h0000_00B0);
    tick(3);
    chk(outs, 32'h0000_0001);
    apb(1'b0, `CTU_ADDR_STATE, 32'h0000_0000);
    chk(rdv, 32'h0000_0002);
    apb(1'b1, `CTU_ADDR_POWER, 32'h0000_0002);
    apb(1'b1, `CTU_ADDR_CON_HIGH, 32'h0000_0090);
    tick(3);
    chk(outs, 32'h0000_0001);
    apb(1'b1, `CTU_ADDR_POWER, 32'h0000_0000);
    tick(3);
    chk(outs, 32'h0000_0101);
    apb(1'b1, `CTU_ADDR_CON_LOW, 32'h0000_0000);
    tick(3);
    chk(outs, 32'h0000_0001);
    $display("power test done");
  endtask
  task automatic t_rerun;
    apb(1'b1, `CTU_ADDR_CON_HIGH, 32'h0000_0088);
    apb(1'b1, `CTU_ADDR_CON_LOW, 32'h0000_0008);
    fire(2'b10, 16);
    apb(1'b0, `CTU_ADDR_CON_LOW, 32'h0000_0000);
    chk(rdv, 32'h0000_0009);
    chk(outs, 32'h0000_0101);
    @(posedge pclk);
    presetn <= 1'b0;
    tick(2);
    presetn <= 1'b1;
    chk(outs, 32'h0000_0000);
    apb(1'b0, `CTU_ADDR_CON_LOW, 32'h0000_0000);
    chk(rdv, 32'h0000_0000);
    apb(1'b0, `CTU_ADDR_CUR_CTRL, 32'h0000_0000);
    chk(rdv, 32'h0000_0000);
    $display("reset during measurement test done");
  endtask
  task automatic report_and_stop;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      $display("ERROR %0t: timeout", $time);
      report_and_stop;
    end
  end
  initial
  begin
    tick(16);
    presetn <= 1'b1;
    t_reset;
    t_regs;
    t_edge;
    t_block;
    t_power;
    t_rerun;
    report_and_stop;
  end
endmodule
`default_nettype wire
